/* pkg/wdt_pkg.sv */
// constants for the watchdog / interval timer block
// assumes a byte-wide register port on the core clock
package wdt_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    // register offsets (read and write addresses)
    localparam logic [7:0] ADDR_CTRL_STATUS = 8'h00_A8;
    localparam logic [7:0] ADDR_COUNT = 8'h00_A9;
    localparam logic [7:0] ADDR_RST_CTRL = 8'h00_AB;
    localparam logic [7:0] ADDR_RST_CTRL_WR = 8'h00_AA;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h00_B0;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h00_B1;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h00_B2;
    // control/status fields
    localparam int OVF_BIT = 7;
    localparam int MODE_BIT = 6;
    localparam int TME_BIT = 5;
    localparam int CKS_LSB = 0;
    localparam logic [7:0] CTRL_FIXED_ONES = 8'h00_18;
    // reset control fields
    localparam int WATCHDOG_RESET_FLAG_BIT = 7;
    localparam int RESET_OUT_ENABLE_BIT = 6;
    localparam logic [7:0] RST_FIXED_ONES = 8'h00_3F;
    // interrupt status bits
    localparam int IRQ_OVF = 0;
    localparam int IRQ_WDOG = 1;
    localparam int IRQ_W = 2;
    // prescaler width, counter maximum and unmapped read value
    localparam int PRE_W = 12;
    localparam logic [7:0] COUNT_MAX = 8'h00_FF;
    localparam logic [7:0] UNMAPPED_READ = 8'h00_00;
    // internal reset pulse length, in ns, and its cycle count at 125 MHz
    localparam int CLK_PERIOD_PS = 8000;
    localparam int WDOG_PULSE_NS = 64;
    localparam int WDOG_PULSE_CYC = (WDOG_PULSE_NS * 1000) / CLK_PERIOD_PS;
    localparam logic [3:0] WDOG_PULSE_CNT = 4'(WDOG_PULSE_CYC);
endpackage : wdt_pkg

/* hdl/wdt_prescaler.sv */
// free-running divider giving a one-cycle tick at the selected rate
// assumes a single core clock and a synchronous active-high clear
`timescale 1ns/1ps
module wdt_prescaler (
    input wire logic clk,
    input wire logic clr,
    input wire logic [2:0] sel,
    output logic tick
);
    import wdt_pkg::*;

    logic [PRE_W-1:0] div_q;
    logic [PRE_W-1:0] mask_t;

    // terminal mask for each clock select code
    function automatic logic [PRE_W-1:0] div_mask(input logic [2:0] s);
        case (s)
            3'd0: div_mask = 12'h0_001;
            3'd1: div_mask = 12'h0_01F;
            3'd2: div_mask = 12'h0_03F;
            3'd3: div_mask = 12'h0_07F;
            3'd4: div_mask = 12'h0_0FF;
            3'd5: div_mask = 12'h0_1FF;
            3'd6: div_mask = 12'h0_7FF;
            default: div_mask = 12'h0_FFF;
        endcase
    endfunction : div_mask

    assign mask_t = div_mask(sel);

    always_ff @(posedge clk) begin
        if (clr) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 12'h0_001;
        end
    end

    // divide by 2,32,64,128,256,512,2048,4096
    assign tick = !clr && ((div_q & mask_t) == mask_t);
endmodule : wdt_prescaler

/* hdl/wdt_timer.sv */
// watchdog / interval timer with byte register port and interrupt
// assumes bus strobes synchronous to CORE_CLK, one cycle each
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
module wdt_timer (
    input wire logic CORE_CLK,
    input wire logic SRST,
    input wire logic [wdt_pkg::ADDR_W-1:0] ADDR,
    input wire logic [wdt_pkg::DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [wdt_pkg::DATA_W-1:0] RDATA,
    output logic INTERVAL_IRQ,
    output logic INTERNAL_RESET,
    output logic RESET_OUT,
    output logic IRQ
);
    import wdt_pkg::*;

    typedef enum logic [1:0] {
        ST_RUN = 2'b01,
        ST_RESET = 2'b10
    } wd_state_e;

    wd_state_e state_q;
    logic overflow_flag_q;
    logic timer_mode_select_q;
    logic timer_enable_bit_q;
    logic [2:0] clock_select_q;
    logic [7:0] count_register_q;
    logic watchdog_reset_flag_q;
    logic reset_out_enable_q;
    logic ovf_seen_q;
    logic watchdog_reset_flag_seen_q;
    logic [IRQ_W-1:0] irq_status_q;
    logic [IRQ_W-1:0] irq_enable_q;
    logic [3:0] pulse_q;
    logic tick;
    logic wrap;
    logic wd_fire;
    logic wr_ctrl;
    logic wr_count;
    logic wr_rst;
    logic rd_ctrl;
    logic rd_rst;
    logic [7:0] rdata_d;

    assign wr_ctrl = WR && (ADDR == ADDR_CTRL_STATUS);
    assign wr_count = WR && (ADDR == ADDR_COUNT);
    assign wr_rst = WR && (ADDR == ADDR_RST_CTRL_WR);
    assign rd_ctrl = RD && (ADDR == ADDR_CTRL_STATUS);
    assign rd_rst = RD && (ADDR == ADDR_RST_CTRL);

    wdt_prescaler u_pre (
        .clk(CORE_CLK),
        .clr(SRST || !timer_enable_bit_q),
        .sel(clock_select_q),
        .tick(tick)
    );

    // counter increments only while enabled
    assign wrap = timer_enable_bit_q && tick && (count_register_q == COUNT_MAX);
    assign wd_fire = wrap && timer_mode_select_q;

    // control fields
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            timer_mode_select_q <= 1'b0;
            timer_enable_bit_q <= 1'b0;
            clock_select_q <= 3'd0;
        end else if (wr_ctrl) begin
            timer_mode_select_q <= WDATA[MODE_BIT];
            timer_enable_bit_q <= WDATA[TME_BIT];
            clock_select_q <= WDATA[CKS_LSB +: 3];
        end
    end

    // counter: cleared and halted while disabled
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            count_register_q <= 8'h00_00;
        end else if (!timer_enable_bit_q) begin
            count_register_q <= 8'h00_00;
        end else if (wr_count) begin
            count_register_q <= WDATA;
        end else if (tick) begin
            count_register_q <= count_register_q + 8'h00_01;
        end
    end

    // overflow flag: set wins over clear
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            overflow_flag_q <= 1'b0;
            ovf_seen_q <= 1'b0;
        end else begin
            if (wrap) begin
                overflow_flag_q <= 1'b1;
            end else if (wr_ctrl && !WDATA[OVF_BIT] && ovf_seen_q) begin
                overflow_flag_q <= 1'b0;
            end
            if (rd_ctrl && overflow_flag_q) begin
                ovf_seen_q <= 1'b1;
            end else if (wr_ctrl || !overflow_flag_q) begin
                ovf_seen_q <= 1'b0;
            end
        end
    end

    // reset control: flag survives internal reset, cleared by pin reset
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            watchdog_reset_flag_q <= 1'b0;
            reset_out_enable_q <= 1'b0;
            watchdog_reset_flag_seen_q <= 1'b0;
        end else begin
            if (wd_fire) begin
                watchdog_reset_flag_q <= 1'b1;
            end else if (wr_rst && !WDATA[WATCHDOG_RESET_FLAG_BIT] && watchdog_reset_flag_seen_q) begin
                watchdog_reset_flag_q <= 1'b0;
            end
            if (wr_rst) begin
                reset_out_enable_q <= WDATA[RESET_OUT_ENABLE_BIT];
            end
            if (rd_rst && watchdog_reset_flag_q) begin
                watchdog_reset_flag_seen_q <= 1'b1;
            end else if (wr_rst || !watchdog_reset_flag_q) begin
                watchdog_reset_flag_seen_q <= 1'b0;
            end
        end
    end

    // internal reset pulse sequencer
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            state_q <= ST_RUN;
            pulse_q <= 4'd0;
        end else begin
            case (state_q)
                ST_RUN: begin
                    if (wd_fire) begin
                        state_q <= ST_RESET;
                        pulse_q <= WDOG_PULSE_CNT - 4'd1;
                    end
                end
                ST_RESET: begin
                    if (pulse_q == 4'd0) begin
                        state_q <= ST_RUN;
                    end else begin
                        pulse_q <= pulse_q - 4'd1;
                    end
                end
                default: state_q <= ST_RUN;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            INTERNAL_RESET <= 1'b0;
            RESET_OUT <= 1'b0;
        end else begin
            INTERNAL_RESET <= (state_q == ST_RESET);
            RESET_OUT <= (state_q == ST_RESET) && reset_out_enable_q;
        end
    end

    // interval interrupt request while flag set in interval mode with the timer enabled
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            INTERVAL_IRQ <= 1'b0;
        end else begin
            INTERVAL_IRQ <= timer_enable_bit_q && !timer_mode_select_q
                && (overflow_flag_q || wrap);
        end
    end

    // sticky event status, clear register, enable register
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            irq_status_q <= '0;
            irq_enable_q <= '0;
        end else begin
            for (int i = 0; i < IRQ_W; i++) begin
                if ((i == IRQ_OVF && wrap && !timer_mode_select_q) || (i == IRQ_WDOG && wd_fire)) begin
                    irq_status_q[i] <= 1'b1;
                end else if (WR && ADDR == ADDR_IRQ_CLEAR && WDATA[i]) begin
                    irq_status_q[i] <= 1'b0;
                end
            end
            if (WR && ADDR == ADDR_IRQ_ENABLE) begin
                irq_enable_q <= WDATA[IRQ_W-1:0];
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(irq_status_q & irq_enable_q);
        end
    end

    // read mux
    always_comb begin
        rdata_d = UNMAPPED_READ;
        if (ADDR == ADDR_CTRL_STATUS) begin
            rdata_d = CTRL_FIXED_ONES;
            rdata_d[OVF_BIT] = overflow_flag_q;
            rdata_d[MODE_BIT] = timer_mode_select_q;
            rdata_d[TME_BIT] = timer_enable_bit_q;
            rdata_d[CKS_LSB +: 3] = clock_select_q;
        end else if (ADDR == ADDR_COUNT) begin
            rdata_d = count_register_q;
        end else if (ADDR == ADDR_RST_CTRL) begin
            rdata_d = RST_FIXED_ONES;
            rdata_d[WATCHDOG_RESET_FLAG_BIT] = watchdog_reset_flag_q;
            rdata_d[RESET_OUT_ENABLE_BIT] = reset_out_enable_q;
        end else if (ADDR == ADDR_IRQ_STATUS) begin
            rdata_d = {{(8-IRQ_W){1'b0}}, irq_status_q};
        end else if (ADDR == ADDR_IRQ_ENABLE) begin
            rdata_d = {{(8-IRQ_W){1'b0}}, irq_enable_q};
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            RDATA <= 8'h00_00;
        end else if (RD) begin
            RDATA <= rdata_d;
        end else begin
            RDATA <= 8'h00_00;
        end
    end

    // assertions
    wrap_sets_ovf_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
        wrap |=> overflow_flag_q) else $error("overflow not set on wrap");

    sequence read_at_one_s;
        rd_ctrl && overflow_flag_q;
    endsequence
    ovf_clear_needs_read_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
        overflow_flag_q && !$past(ovf_seen_q) && !ovf_seen_q ##1 1'b1 |-> overflow_flag_q)
        else $error("overflow cleared without read");
    ovf_read_clear_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
        read_at_one_s ##1 (wr_ctrl && !WDATA[OVF_BIT] && !wrap) |=> !overflow_flag_q)
        else $error("overflow not cleared");
    ovf_no_sw_set_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
        !overflow_flag_q && !wrap |=> !overflow_flag_q)
        else $error("overflow set without wrap");
    interval_irq_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
        wrap && !timer_mode_select_q |=> INTERVAL_IRQ)
        else $error("no interval request");
    wdog_pulse_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
        wd_fire |=> ##1 INTERNAL_RESET[*8] ##1 !INTERNAL_RESET)
        else $error("bad reset pulse");
    watchdog_reset_flag_set_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
        wd_fire |=> watchdog_reset_flag_q) else $error("reset flag not set");
    watchdog_reset_flag_pin_clear_a: assert property (@(posedge CORE_CLK)
        SRST |=> !watchdog_reset_flag_q) else $error("reset flag survives pin");
    watchdog_reset_flag_hold_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
        watchdog_reset_flag_q && !watchdog_reset_flag_seen_q |=> watchdog_reset_flag_q)
        else $error("reset flag cleared without read");
    disabled_zero_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
        !timer_enable_bit_q |=> count_register_q == 8'h00_00)
        else $error("counter runs while disabled");
    div2_tick_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
        timer_enable_bit_q && clock_select_q == 3'd0 && tick && !wr_ctrl ##1 !wr_ctrl
        |-> !tick ##1 tick) else $error("divide by two wrong");
endmodule : wdt_timer

/* verification/wdt_cpu_model.sv */
// cpu side register bus master for the watchdog timer
// assumes its tasks are entered just after a rising clock edge
`timescale 1ns/1ps
module wdt_cpu_model (
    input wire logic clk,
    input wire logic [7:0] rdata,
    output logic [7:0] addr,
    output logic [7:0] wdata,
    output logic wr,
    output logic rd
);
    initial begin
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
    end
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask : put
    // flags are read before the clearing write
    task automatic get(input logic [7:0] a, output logic [7:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask : get
    // read then write on the next edge, no gap between the strobes
    task automatic get_put(input logic [7:0] a, input logic [7:0] dw, output logic [7:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        wr <= 1'b1;
        wdata <= dw;
        @(posedge clk);
        d = rdata;
        wr <= 1'b0;
        @(posedge clk);
    endtask : get_put
endmodule : wdt_cpu_model

/* verification/watchdog_interval_timer_test.sv */
// self-checking bench for the watchdog / interval timer
// assumes the cpu bus model drives all register port inputs
`timescale 1ns/1ps
module watchdog_interval_timer_test;
    import wdt_pkg::*;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] addr, wdata, rdata, v;
    logic wr, rd, int_irq, int_rst, rst_out, irq, quiet;
    int n_mismatch = 0;
    int num_checks = 0;
    int len;
    int divs[8] = '{2, 32, 64, 128, 256, 512, 2048, 4096};

    wdt_timer dut_u (.CORE_CLK(core_clk), .SRST(srst), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .INTERVAL_IRQ(int_irq),
        .INTERNAL_RESET(int_rst), .RESET_OUT(rst_out), .IRQ(irq));
    wdt_cpu_model bus_u (.clk(core_clk), .rdata(rdata), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd));

    initial begin
        forever #4 core_clk = ~core_clk;
    end

    task automatic summarize();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t byte %h want %h", $time, got, exp);
        end
    endtask : chk_byte

    task automatic chk_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t bit %b want %b", $time, got, exp);
        end
    endtask : chk_bit

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        bus_u.get(a, v);
        chk_byte(v, exp);
    endtask : rd_chk

    task automatic irq_chk(input logic exp);
        @(posedge core_clk);
        chk_bit(irq, exp);
    endtask : irq_chk

    // length of the next reset pulse; quiet drops if rst_out or int_irq moves while int_rst is timed
    task automatic pulse(input bit outp);
        logic s;
        len = 0;
        quiet = 1'b1;
        for (int i = 0; i < 600; i++) begin
            @(posedge core_clk);
            s = outp ? rst_out : int_rst;
            if (!outp && (rst_out !== 1'b0 || int_irq !== 1'b0)) quiet = 1'b0;
            if (s === 1'b1) len++;
            else if (len > 0) break;
        end
    endtask : pulse

    task automatic t_reset_vals();
        rd_chk(ADDR_CTRL_STATUS, CTRL_FIXED_ONES);
        rd_chk(ADDR_COUNT, 8'h00);
        rd_chk(ADDR_RST_CTRL, RST_FIXED_ONES);
        rd_chk(8'hC0, UNMAPPED_READ);
        bus_u.put(ADDR_CTRL_STATUS, 8'h80);
        rd_chk(ADDR_CTRL_STATUS, CTRL_FIXED_ONES);
    endtask : t_reset_vals

    task automatic t_interval();
        // counter is held at zero until enabled, so enable first
        bus_u.put(ADDR_CTRL_STATUS, 8'h20);
        bus_u.put(ADDR_COUNT, COUNT_MAX);
        for (int i = 0; i < 50 && int_irq !== 1'b1; i++) @(posedge core_clk);
        chk_bit(int_irq, 1'b1);
        // write of zero without a prior read must not clear
        bus_u.put(ADDR_CTRL_STATUS, 8'h20);
        rd_chk(ADDR_CTRL_STATUS, 8'hB8);
        rd_chk(ADDR_IRQ_STATUS, 8'h01);
        chk_bit(irq, 1'b0);
        bus_u.put(ADDR_IRQ_ENABLE, 8'h01);
        irq_chk(1'b1);
        bus_u.put(ADDR_IRQ_CLEAR, 8'h01);
        irq_chk(1'b0);
        bus_u.get_put(ADDR_CTRL_STATUS, 8'h00, v);
        chk_byte(v, 8'hB8);
        rd_chk(ADDR_CTRL_STATUS, CTRL_FIXED_ONES);
        rd_chk(ADDR_COUNT, 8'h00);
        chk_bit(int_irq, 1'b0);
    endtask : t_interval

    task automatic t_clock_sel();
        for (int k = 0; k < 8; k++) begin
            bus_u.put(ADDR_CTRL_STATUS, 8'h00);
            bus_u.put(ADDR_CTRL_STATUS, 8'h20 | 8'(k));
            repeat (divs[k] * 2 + divs[k] / 2) @(posedge core_clk);
            bus_u.get(ADDR_COUNT, v);
            chk_bit(v >= 8'h02 && v <= 8'h03, 1'b1);
        end
        bus_u.put(ADDR_CTRL_STATUS, 8'h00);
    endtask : t_clock_sel

    task automatic t_watchdog();
        bus_u.put(ADDR_CTRL_STATUS, 8'h60);
        bus_u.put(ADDR_COUNT, COUNT_MAX);
        pulse(1'b0);
        chk_byte(8'(len), 8'(WDOG_PULSE_CYC));
        chk_bit(quiet, 1'b1);
        rd_chk(ADDR_IRQ_STATUS, 8'h02);
        chk_bit(irq, 1'b0);
        bus_u.put(ADDR_IRQ_ENABLE, 8'h02);
        irq_chk(1'b1);
        bus_u.put(ADDR_IRQ_CLEAR, 8'h02);
        irq_chk(1'b0);
        rd_chk(ADDR_RST_CTRL, 8'hBF);
        bus_u.put(ADDR_RST_CTRL_WR, 8'hC0);
        rd_chk(ADDR_RST_CTRL, 8'hFF);
        bus_u.put(ADDR_RST_CTRL_WR, 8'h40);
        rd_chk(ADDR_RST_CTRL, 8'h7F);
        bus_u.put(ADDR_COUNT, COUNT_MAX);
        pulse(1'b1);
        chk_byte(8'(len), 8'(WDOG_PULSE_CYC));
        rd_chk(ADDR_RST_CTRL, 8'hFF);
        srst <= 1'b1;
        @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        rd_chk(ADDR_RST_CTRL, RST_FIXED_ONES);
    endtask : t_watchdog

    initial begin
        repeat (20) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        t_reset_vals();
        t_interval();
        t_clock_sel();
        t_watchdog();
        summarize();
    end

    // hang guard well beyond the roughly 18k cycles the tests need
    initial begin
        repeat (80000) @(posedge core_clk);
        n_mismatch++;
        summarize();
    end
endmodule : watchdog_interval_timer_test
